// file: rtl/spectrograph_control_sequencer.sv
`timescale 1ns/100ps
module spectrograph_control_sequencer (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // ahb-lite register slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // host port pins
    input wire logic load_start_pulse_i,
    input wire logic start_pulse_i,
    input wire logic host_write_strobe_n_i,
    input wire logic host_read_strobe_n_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic [2:0] byte_group_enable_o,
    output logic byte_valid_strobe_n_o,
    output logic readout_buffer_full_o,
    // memory loading
    output logic [7:0] load_data_o,
    output logic [spec_seq_pkg::LADDR_W-1:0] load_addr_o,
    output logic buffer_release_n_o,
    output logic bank_write_enable_n_o,
    output logic [spec_seq_pkg::NUM_BANKS-1:0] chip_enable_n_o,
    output logic [spec_seq_pkg::NUM_BANKS-1:0] bank_carry_o,
    output logic address_carry_pulse_o,
    output logic load_address_clear_o,
    output logic fifo_reset_o,
    output logic load_phase_done_o,
    // control word shifting
    output logic control_shift_clock_o,
    output logic control_serial_data_o,
    output logic [2:0] control_stage_o,
    // mode outputs
    output logic known_data_select_o,
    output logic cross_select_o,
    output logic [8:0] channel_count_o,
    // fft sequencer
    output logic ram_output_enable_o,
    output logic pipeline_init_master_o,
    output logic [spec_seq_pkg::NUM_FFT_STAGES-1:0] stage_init_o,
    // datapath
    input wire logic [spec_seq_pkg::DATA_W-1:0] sample_data_i,
    input wire logic [spec_seq_pkg::DATA_W-1:0] known_data_i,
    input wire logic [spec_seq_pkg::TWID_W-1:0] twiddle_i,
    input wire logic [spec_seq_pkg::DATA_W-1:0] fft_out_i,
    output logic [spec_seq_pkg::DATA_W-1:0] fft_in_o,
    output logic [spec_seq_pkg::TWID_W-1:0] twiddle_o,
    output logic [spec_seq_pkg::MAC_W-1:0] mac_in_o,
    // accumulator side
    input wire logic acc_valid_i,
    input wire logic [spec_seq_pkg::ACC_W-1:0] acc_result_i,
    output logic [spec_seq_pkg::BUF_AW:0] integ_addr_o,
    output logic [spec_seq_pkg::BUF_AW:0] dump_addr_o
);
    import spec_seq_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [11:0] sync1_ff, sync2_ff, prev_ff;
    wire [11:0] pins = {host_data_i, host_write_strobe_n_i, host_read_strobe_n_i,
                        load_start_pulse_i, start_pulse_i};
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_ff <= 12'h00C;
            sync2_ff <= 12'h00C;
            prev_ff <= 12'h00C;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end
    wire [7:0] host_byte = sync2_ff[11:4];
    wire wr_rise = sync2_ff[3] & ~prev_ff[3];
    wire rd_fall = ~sync2_ff[2] & prev_ff[2];
    wire load_go = sync2_ff[1] & ~prev_ff[1];
    wire start_go = sync2_ff[0] & ~prev_ff[0];

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic [LADDR_W-1:0] bank_len_ff [NUM_BANKS];
    logic wr_pend_ff;
    logic [7:0] waddr_ff;
    logic [31:0] hrdata_ff;
    logic [7:0] mode_ff;
    seq_state_t state_ff;
    logic [2:0] bank_ff;
    wire take = hsel_i & htrans_i[1] & hready_i;
    wire [7:0] aoff = haddr_i[7:0];
    wire [2:0] bank_sel = 3'((aoff - BANK_LEN_BASE) >> 2);
    wire bank_hit = aoff >= BANK_LEN_BASE && bank_sel < 3'(NUM_BANKS) && aoff[1:0] == 2'b00;
    wire [31:0] status_word = {16'h0000, readout_buffer_full_o, load_phase_done_o, 8'h00, bank_ff,
                               state_ff};
    wire [31:0] rd_mux = aoff == STATUS_OFFS ? status_word :
                         aoff == MODE_OFFS ? {24'h00_0000, mode_ff} :
                         bank_hit ? {21'h00_0000, bank_len_ff[bank_sel]} : 32'h0000_0000;
    wire [2:0] wbank = 3'((waddr_ff - BANK_LEN_BASE) >> 2);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_pend_ff <= 1'b0;
            waddr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= take & hwrite_i & bank_hit;
            waddr_ff <= aoff;
            hrdata_ff <= (take & ~hwrite_i) ? rd_mux : 32'h0000_0000;
        end
    end
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_len
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    bank_len_ff[g] <= BANK_LEN_RESET;
                end else if (wr_pend_ff && wbank == 3'(g)) begin
                    bank_len_ff[g] <= hwdata_i[LADDR_W-1:0];
                end
            end
        end
    endgenerate
    assign hrdata_o = hrdata_ff;
    // zero wait states
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // ----------------------------------------
    // loading: strobes, address, banks
    // ----------------------------------------
    logic [1:0] wr_ph_ff;
    logic [7:0] byte_ff;
    logic [LADDR_W-1:0] laddr_ff;
    logic [NUM_BANKS-1:0] carry_ff;
    logic acarry_ff, fifo_rst_ff, done_ff;
    logic [4:0] fcnt_ff;
    logic [7:0] fifo_mem [FIFO_BYTES];
    logic shift_end;
    wire loading = state_ff == ST_LOAD_BANKS || state_ff == ST_LOAD_FIFO;
    wire wr_commit = wr_ph_ff[1];
    wire last_addr = laddr_ff == bank_len_ff[bank_ff] - 11'd1;
    wire bank_carry = wr_commit && state_ff == ST_LOAD_BANKS && last_addr;
    wire last_bank = bank_ff == 3'(NUM_BANKS - 1);
    wire fifo_wr = wr_commit && state_ff == ST_LOAD_FIFO;
    wire fifo_last = fcnt_ff == 5'(FIFO_BYTES - 1);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ph_ff <= 2'b00;
            byte_ff <= 8'h00;
        end else begin
            wr_ph_ff <= {wr_ph_ff[0], wr_rise & loading};
            if (wr_rise) begin
                byte_ff <= host_byte;
            end
        end
    end
    assign buffer_release_n_o = ~(wr_ph_ff[0] | wr_ph_ff[1]);
    assign bank_write_enable_n_o = ~wr_ph_ff[1];
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            laddr_ff <= '0;
            bank_ff <= 3'd0;
            carry_ff <= '0;
            acarry_ff <= 1'b0;
            fcnt_ff <= 5'd0;
            fifo_rst_ff <= 1'b0;
        end else begin
            acarry_ff <= bank_carry;
            fifo_rst_ff <= bank_carry & last_bank;
            if (load_go && state_ff == ST_IDLE) begin
                laddr_ff <= '0;
                bank_ff <= 3'd0;
                carry_ff <= '0;
            end else if (bank_carry) begin
                laddr_ff <= '0;
                carry_ff[bank_ff] <= 1'b1;
                bank_ff <= last_bank ? bank_ff : bank_ff + 3'd1;
            end else if (wr_commit && state_ff == ST_LOAD_BANKS) begin
                laddr_ff <= laddr_ff + 11'd1;
            end
            if (fifo_rst_ff) begin
                fcnt_ff <= 5'd0;
            end else if (fifo_wr && !fifo_last) begin
                fcnt_ff <= fcnt_ff + 5'd1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (fifo_wr) begin
            fifo_mem[fcnt_ff] <= byte_ff;
        end
    end
    assign load_data_o = byte_ff;
    assign load_addr_o = laddr_ff;
    assign bank_carry_o = carry_ff;
    assign address_carry_pulse_o = acarry_ff;
    assign load_address_clear_o = acarry_ff;
    assign fifo_reset_o = fifo_rst_ff;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_ce
            // one bank loading, all running
            assign chip_enable_n_o[g] = state_ff == ST_RUN ? 1'b0 :
                                        ~(state_ff == ST_LOAD_BANKS && bank_ff == 3'(g));
        end
    endgenerate

    // ----------------------------------------
    // sequencing state
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_IDLE;
            mode_ff <= 8'h00;
            done_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (load_go) begin
                        state_ff <= ST_LOAD_BANKS;
                        done_ff <= 1'b0;
                    end
                end
                ST_LOAD_BANKS: begin
                    if (bank_carry && last_bank) begin
                        state_ff <= ST_LOAD_FIFO;
                    end
                end
                ST_LOAD_FIFO: begin
                    if (fifo_wr && fifo_last) begin
                        mode_ff <= byte_ff;
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (shift_end) begin
                        state_ff <= ST_READY;
                        done_ff <= 1'b1;
                    end
                end
                ST_READY: begin
                    if (start_go) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_ff <= ST_RUN;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
    assign load_phase_done_o = done_ff & carry_ff[NUM_BANKS-1];

    // ----------------------------------------
    // control word shifting
    // ----------------------------------------
    // bit1 shift clock, bit0 advance
    function automatic logic [1:0] shift_table(input logic [2:0] step);
        logic [1:0] w;
        w = 2'b00;
        w[1] = step >= 3'(SHIFT_CYCLES / 2);
        w[0] = step == 3'(SHIFT_CYCLES - 1);
        return w;
    endfunction
    logic [2:0] step_ff, bit_ff;
    logic [4:0] sbyte_ff;
    logic sclk_ff, sdata_ff;
    wire shifting = state_ff == ST_SHIFT;
    wire [1:0] table_word = shift_table(step_ff);
    assign shift_end = shifting && table_word[0] && bit_ff == 3'd7 && sbyte_ff == 5'(CTRL_BYTES - 1);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step_ff <= 3'd0;
            bit_ff <= 3'd0;
            sbyte_ff <= 5'd0;
            sclk_ff <= 1'b0;
            sdata_ff <= 1'b0;
        end else if (!shifting) begin
            step_ff <= 3'd0;
            bit_ff <= 3'd0;
            sbyte_ff <= 5'd0;
            sclk_ff <= 1'b0;
        end else begin
            step_ff <= table_word[0] ? 3'd0 : step_ff + 3'd1;
            sclk_ff <= table_word[1] & ~table_word[0];
            sdata_ff <= fifo_mem[sbyte_ff][3'd7 - bit_ff];
            if (table_word[0]) begin
                bit_ff <= bit_ff + 3'd1;
                if (bit_ff == 3'd7) begin
                    sbyte_ff <= sbyte_ff + 5'd1;
                end
            end
        end
    end
    assign control_shift_clock_o = sclk_ff;
    assign control_serial_data_o = sdata_ff;
    assign control_stage_o = 3'(sbyte_ff >> 2);

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    wire [2:0] chan_raw = mode_ff[MODE_CHAN_LSB +: 3];
    wire [2:0] chan_code = chan_raw > 3'(CHAN_CODE_MAX) ? 3'(CHAN_CODE_MAX) : chan_raw;
    assign channel_count_o = 9'(MAX_CHANNELS >> chan_code);
    assign known_data_select_o = mode_ff[MODE_SRC_BIT];
    assign cross_select_o = mode_ff[MODE_XSPEC_BIT];

    // ----------------------------------------
    // fft sequencer and datapath
    // ----------------------------------------
    localparam int DLY_LEN = STAGE_INIT_DELAY * (NUM_FFT_STAGES - 1);
    logic [9:0] fcyc_ff;
    logic init_ff, oe_ff;
    logic [DLY_LEN-1:0] dly_ff;
    wire running = state_ff == ST_RUN;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fcyc_ff <= 10'd0;
            init_ff <= 1'b0;
            oe_ff <= 1'b0;
            dly_ff <= '0;
            fft_in_o <= '0;
            twiddle_o <= '0;
            mac_in_o <= '0;
        end else begin
            fcyc_ff <= (!running || fcyc_ff == 10'(FFT_FRAME_CYCLES - 1)) ? 10'd0 : fcyc_ff + 10'd1;
            init_ff <= running && fcyc_ff == 10'd0;
            oe_ff <= running && fcyc_ff < 10'(FFT_OE_CYCLES);
            dly_ff <= {dly_ff[DLY_LEN-2:0], init_ff};
            fft_in_o <= mode_ff[MODE_SRC_BIT] ? known_data_i : sample_data_i;
            twiddle_o <= twiddle_i;
            mac_in_o <= {fft_out_i[17:14], fft_out_i[10:7], fft_out_i[3:0]};
        end
    end
    assign pipeline_init_master_o = init_ff;
    assign ram_output_enable_o = oe_ff;
    assign stage_init_o[0] = init_ff;
    generate
        for (g = 1; g < NUM_FFT_STAGES; g++) begin : g_init
            assign stage_init_o[g] = dly_ff[STAGE_INIT_DELAY * g - 1];
        end
    endgenerate

    // ----------------------------------------
    // accumulator addressing and result buffer
    // ----------------------------------------
    logic [BUF_AW-1:0] integ_ff, dump_ff, wptr_ff, rptr_ff;
    logic half_ff, full_ff, bv_ff;
    logic [2:0] grp_ff;
    logic [7:0] hdata_ff;
    logic [ACC_W-1:0] rbuf [BUF_DEPTH];
    wire integ_wrap = integ_ff == 8'(channel_count_o - 9'd1);
    wire buf_wr = acc_valid_i & ~full_ff;
    wire [ACC_W-1:0] rword = rbuf[rptr_ff];
    wire rd_step = rd_fall & full_ff;
    wire [2:0] nxt_grp = grp_ff[2] || grp_ff == 3'b000 ? 3'b001 : {grp_ff[1:0], 1'b0};
    wire [7:0] sel_byte = nxt_grp[1] ? rword[15:8] : nxt_grp[2] ? {6'h00, rword[17:16]} : rword[7:0];
    always_ff @(posedge clk_i) begin
        if (buf_wr) begin
            rbuf[wptr_ff] <= acc_result_i;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            integ_ff <= '0;
            dump_ff <= '0;
            half_ff <= 1'b0;
            wptr_ff <= '0;
            rptr_ff <= '0;
            full_ff <= 1'b0;
            grp_ff <= 3'b000;
            hdata_ff <= 8'h00;
            bv_ff <= 1'b0;
        end else begin
            if (running) begin
                integ_ff <= integ_wrap ? '0 : integ_ff + 8'd1;
                half_ff <= half_ff ^ integ_wrap;
            end
            if (buf_wr) begin
                dump_ff <= dump_ff + 8'd1;
                wptr_ff <= wptr_ff + 8'd1;
                full_ff <= wptr_ff == 8'(BUF_DEPTH - 1);
            end
            bv_ff <= rd_step;
            if (rd_step) begin
                hdata_ff <= sel_byte;
                grp_ff <= nxt_grp;
                if (nxt_grp[2]) begin
                    rptr_ff <= rptr_ff + 8'd1;
                    if (rptr_ff == 8'(BUF_DEPTH - 1)) begin
                        full_ff <= 1'b0;
                    end
                end
            end
        end
    end
    assign integ_addr_o = {half_ff, integ_ff};
    assign dump_addr_o = {~half_ff, dump_ff};
    assign readout_buffer_full_o = full_ff;
    assign byte_group_enable_o = grp_ff;
    assign host_data_o = hdata_ff;
    assign byte_valid_strobe_n_o = ~bv_ff;
endmodule

// file: rtl/spec_seq_pkg.sv
package spec_seq_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int SHIFT_PERIOD_PS = 62500;
    localparam int SHIFT_CYCLES = SHIFT_PERIOD_PS / CLK_PERIOD_PS;
    localparam int FFT_FRAME_CYCLES = 516;
    localparam int FFT_OE_CYCLES = 512;
    localparam int STAGE_INIT_DELAY = 11;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_BANKS = 6;
    localparam int NUM_FFT_STAGES = 5;
    localparam int CTRL_BYTES = 24;
    localparam int FIFO_BYTES = CTRL_BYTES + 1;
    localparam int DATA_W = 18;
    localparam int TWID_W = 10;
    localparam int MAC_W = 12;
    localparam int ACC_W = 18;
    localparam int LADDR_W = 11;
    localparam int BUF_AW = 8;
    localparam int BUF_DEPTH = 256;
    localparam int MAX_CHANNELS = 256;
    localparam int CHAN_CODE_MAX = 5;
    // ----------------------------------------
    // mode byte fields
    // ----------------------------------------
    localparam int MODE_SRC_BIT = 0;
    localparam int MODE_CHAN_LSB = 1;
    localparam int MODE_XSPEC_BIT = 4;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] STATUS_OFFS = 8'h00;
    localparam logic [7:0] MODE_OFFS = 8'h04;
    localparam logic [7:0] BANK_LEN_BASE = 8'h10;
    localparam logic [LADDR_W-1:0] BANK_LEN_RESET = 11'h200;
    typedef enum logic [2:0] {ST_IDLE, ST_LOAD_BANKS, ST_LOAD_FIFO, ST_SHIFT, ST_READY, ST_RUN} seq_state_t;
endpackage

// file: dv/spec_host_board.sv
`timescale 1ns/100ps
module spec_host_board (
    // clock
    input wire logic clk_i,
    // host port pins
    output logic load_start_pulse_o = 1'b0,
    output logic start_pulse_o = 1'b0,
    output logic write_strobe_n_o = 1'b1,
    output logic read_strobe_n_o = 1'b1,
    output logic [7:0] data_o = 8'h00
);
    // ----------------
    // board actions
    // ----------------
    // 3 clocks: enough for the synchronisers
    task automatic pulse(input logic run);
        if (run)
            start_pulse_o <= 1'b1;
        else
            load_start_pulse_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        start_pulse_o <= 1'b0;
        load_start_pulse_o <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic wr_byte(input logic [7:0] b);
        data_o <= b;
        write_strobe_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        write_strobe_n_o <= 1'b1;
        // bus driven with the inverted byte after the hold
        repeat (8) @(posedge clk_i);
        data_o <= ~b;
        @(posedge clk_i);
    endtask
    task automatic rd_byte();
        read_strobe_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        read_strobe_n_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// file: dv/spectrograph_control_sequencer_chk.sv
`timescale 1ns/100ps
module spec_seq_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // loading
    input wire logic [spec_seq_pkg::NUM_BANKS-1:0] chip_enable_n_o,
    input wire logic buffer_release_n_o,
    input wire logic bank_write_enable_n_o,
    input wire logic address_carry_pulse_o,
    input wire logic load_address_clear_o,
    input wire logic [spec_seq_pkg::LADDR_W-1:0] load_addr_o,
    input wire logic [spec_seq_pkg::NUM_BANKS-1:0] bank_carry_o,
    input wire logic fifo_reset_o,
    input wire logic load_phase_done_o,
    input wire logic control_shift_clock_o,
    input wire logic [8:0] channel_count_o,
    // run and readout
    input wire logic pipeline_init_master_o,
    input wire logic [spec_seq_pkg::NUM_FFT_STAGES-1:0] stage_init_o,
    input wire logic byte_valid_strobe_n_o,
    input wire logic [2:0] byte_group_enable_o,
    input wire logic known_data_select_o,
    input wire logic [spec_seq_pkg::DATA_W-1:0] known_data_i,
    input wire logic [spec_seq_pkg::DATA_W-1:0] fft_in_o
);
    import spec_seq_pkg::*;
    int unsigned gap_ff;
    logic seen_ff;
    // cycles since the last master init
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_ff <= 0;
            seen_ff <= 1'b0;
        end else begin
            gap_ff <= pipeline_init_master_o ? 0 : gap_ff + 1;
            seen_ff <= seen_ff | pipeline_init_master_o;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_we_pair;
        (!buffer_release_n_o && !bank_write_enable_n_o) ##1 (buffer_release_n_o && bank_write_enable_n_o);
    endsequence
    sequence s_stages;
        stage_init_o[1] ##11 stage_init_o[2] ##11 stage_init_o[3] ##11 stage_init_o[4];
    endsequence
    property p_wr_order;
        $fell(buffer_release_n_o) |-> bank_write_enable_n_o ##1 s_we_pair;
    endproperty
    property p_one_bank;
        ($countones(chip_enable_n_o) >= NUM_BANKS - 1) || (chip_enable_n_o == '0);
    endproperty
    property p_all_sel;
        (chip_enable_n_o == '0) |-> load_phase_done_o;
    endproperty
    property p_carry;
        address_carry_pulse_o |-> load_address_clear_o ##1 (!address_carry_pulse_o && load_addr_o == '0);
    endproperty
    property p_fifo_clr;
        $rose(bank_carry_o[NUM_BANKS-1]) |-> ##[0:3] fifo_reset_o;
    endproperty
    property p_shift;
        $rose(control_shift_clock_o) |-> control_shift_clock_o [*2] ##1 !control_shift_clock_o [*4];
    endproperty
    property p_frame;
        seen_ff |-> (pipeline_init_master_o == (gap_ff == FFT_FRAME_CYCLES - 1));
    endproperty
    property p_stage;
        pipeline_init_master_o |-> stage_init_o[0] ##11 s_stages;
    endproperty
    property p_chan;
        load_phase_done_o |-> channel_count_o inside {9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008};
    endproperty
    property p_valid;
        !byte_valid_strobe_n_o |-> $onehot(byte_group_enable_o) ##1 byte_valid_strobe_n_o;
    endproperty
    property p_pass;
        known_data_select_o && $past(known_data_select_o) |-> fft_in_o == $past(known_data_i);
    endproperty
    a_wr_order: assert property (p_wr_order) else $error("we order");
    a_one_bank: assert property (p_one_bank) else $error("bank select");
    a_all_sel: assert property (p_all_sel) else $error("early select");
    a_carry: assert property (p_carry) else $error("carry");
    a_fifo_clr: assert property (p_fifo_clr) else $error("fifo reset");
    a_shift: assert property (p_shift) else $error("shift clock");
    a_frame: assert property (p_frame) else $error("frame");
    a_stage: assert property (p_stage) else $error("stage init");
    a_chan: assert property (p_chan) else $error("channels");
    a_valid: assert property (p_valid) else $error("byte valid");
    a_pass: assert property (p_pass) else $error("known data");
endmodule

// file: dv/spectrograph_control_sequencer_tb.sv
`timescale 1ns/100ps
module spectrograph_control_sequencer_tb;
    import spec_seq_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0, hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic hreadyout_o, ld_go, run_go, wr_n, rd_n, bvs_n, full, done, brel_n, bwe_n;
    logic sclk, sclk_q, sdat, kds, xsel, oe, init, acc_v = 1'b0;
    logic [7:0] hdat, hout, ldat, mode, sh_bits, cap_d, cap_b;
    logic [7:0] exp_b [3] = '{8'h5a, 8'hc3, 8'h02};
    logic [2:0] grp, cap_g;
    logic [5:0] ce_n, bcy, cap_ce;
    logic [8:0] chan;
    logic [10:0] ladr, cap_a;
    logic [17:0] smp = 18'h0, acc = 18'h0;
    int errors = 0, tests_run = 0, we_cnt, sh_cnt, rv_cnt, n;
    always #5 clk_i = ~clk_i;
    spec_host_board host_u (.clk_i(clk_i), .load_start_pulse_o(ld_go), .start_pulse_o(run_go),
        .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n), .data_o(hdat));
    spectrograph_control_sequencer dut_u (.*, .hsize_i(3'h2), .hready_i(hreadyout_o), .hresp_o(),
        .load_start_pulse_i(ld_go),
        .start_pulse_i(run_go), .host_write_strobe_n_i(wr_n), .host_read_strobe_n_i(rd_n), .host_data_i(hdat),
        .host_data_o(hout), .byte_group_enable_o(grp), .byte_valid_strobe_n_o(bvs_n),
        .readout_buffer_full_o(full), .load_data_o(ldat), .load_addr_o(ladr), .buffer_release_n_o(brel_n),
        .bank_write_enable_n_o(bwe_n), .chip_enable_n_o(ce_n), .bank_carry_o(bcy), .address_carry_pulse_o(),
        .load_address_clear_o(), .fifo_reset_o(), .load_phase_done_o(done), .control_shift_clock_o(sclk),
        .control_serial_data_o(sdat), .control_stage_o(), .known_data_select_o(kds), .cross_select_o(xsel),
        .channel_count_o(chan), .ram_output_enable_o(oe), .pipeline_init_master_o(init), .stage_init_o(),
        .sample_data_i(smp), .known_data_i(~smp), .twiddle_i(smp[TWID_W-1:0]), .fft_out_i(smp + 18'h1),
        .fft_in_o(), .twiddle_o(), .mac_in_o(), .acc_valid_i(acc_v), .acc_result_i(acc), .integ_addr_o(),
        .dump_addr_o());
    // ----------------
    // monitors
    // ----------------
    always @(posedge clk_i) begin
        smp <= smp + 18'h0_0101;
        if (!bwe_n) begin
            we_cnt++;
            {cap_ce, cap_d, cap_a} = {ce_n, ldat, ladr};
        end
        if (!bvs_n) begin
            rv_cnt++;
            {cap_b, cap_g} = {hout, grp};
        end
        if (sclk && !sclk_q) begin
            sh_cnt++;
            sh_bits = {sh_bits[6:0], sdat};
        end
        sclk_q = sclk;
    end
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        haddr_i <= a;
        hwrite_i <= w;
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic do_reset();
        nrst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        {we_cnt, sh_cnt, rv_cnt} = '0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wrap_up();
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------
    // tests
    // ----------------
    initial begin
        for (int m = 0; m < 7; m++) begin
            do_reset();
            if (m == 0) begin
                chk(ce_n, 6'h3f);
                ahb(1'b0, BANK_LEN_BASE + 8'h14, 32'h0);
                chk(rd, BANK_LEN_RESET);
                ahb(1'b1, STATUS_OFFS, 32'hffff_ffff);
                ahb(1'b0, 32'h0000_000c, 32'h0);
                chk(rd, 32'h0);
                host_u.wr_byte(8'h77);
                host_u.pulse(1'b1);
                ahb(1'b0, STATUS_OFFS, 32'h0);
                chk(rd, 32'h0);
                chk(we_cnt, 32'h0);
            end
            for (n = 0; n < NUM_BANKS; n++)
                ahb(1'b1, BANK_LEN_BASE + 4 * n, 32'h2);
            host_u.pulse(1'b0);
            ahb(1'b0, STATUS_OFFS, 32'h0);
            chk(rd[2:0], 3'h1);
            for (int b = 0; b < NUM_BANKS; b++) begin
                for (int i = 0; i < 2; i++) begin
                    host_u.wr_byte(8'(16 * b + i + 1));
                    chk(we_cnt, 2 * b + i + 1);
                    chk(cap_d, 16 * b + i + 1);
                    chk(cap_a, i);
                    chk(cap_ce, 6'(~(6'h1 << b)));
                end
                chk(bcy[b], 1'b1);
            end
            ahb(1'b0, STATUS_OFFS, 32'h0);
            chk(rd[2:0], 3'h2);
            for (n = 0; n < CTRL_BYTES; n++)
                host_u.wr_byte(8'h3c ^ 8'(n));
            mode = {3'h0, m[0], m[2:0], !m[0]};
            host_u.wr_byte(mode);
            for (n = 0; done !== 1'b1 && n < 3000; n++) @(posedge clk_i);
            chk(sh_cnt, 8 * CTRL_BYTES);
            chk(sh_bits, 8'h3c ^ 8'(CTRL_BYTES - 1));
            ahb(1'b0, MODE_OFFS, 32'h0);
            chk(rd, mode);
            chk(chan, 256 >> (m > 5 ? 5 : m));
            chk(kds, !m[0]);
            chk(xsel, m[0]);
            ahb(1'b0, STATUS_OFFS, 32'h0);
            chk(rd[14], 1'b1);
        end
        host_u.pulse(1'b1);
        chk(ce_n, 6'h0);
        for (n = 0; init !== 1'b1 && n < 1000; n++) @(posedge clk_i);
        n = 0;
        repeat (FFT_FRAME_CYCLES) begin
            @(posedge clk_i);
            n += (oe === 1'b1);
        end
        chk(n, FFT_OE_CYCLES);
        acc <= 18'h2_c35a;
        acc_v <= 1'b1;
        repeat (BUF_DEPTH + 40) @(posedge clk_i);
        acc_v <= 1'b0;
        chk(full, 1'b1);
        for (n = 0; n < 3 * BUF_DEPTH; n++) begin
            host_u.rd_byte();
            chk(rv_cnt, n + 1);
            chk(cap_b, exp_b[n % 3]);
            chk(cap_g, 3'h1 << (n % 3));
        end
        chk(full, 1'b0);
        wrap_up();
    end
    // watchdog: about three times the expected run
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        wrap_up();
    end
endmodule
bind spectrograph_control_sequencer spec_seq_chk chk_u (.*);
